// ### ext_irq.sv
`timescale 1ns/1ps
module ext_irq
    import ext_irq_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // External pins
    input  wire logic [1:0]  ext_irq_pins,
    input  wire logic [15:0] pin_change_inputs,
    // Core interrupt logic
    input  wire logic [1:0]  ext_irq_ack,
    input  wire logic [1:0]  pin_change_ack,
    output logic             ext_irq_a_req,
    output logic             ext_irq_b_req,
    output logic             pin_change_group_lo_irq,
    output logic             pin_change_group_hi_irq,
    output logic             wake_req
);

    // ****************************************************************
    // Reset release and pin synchronisers
    // ****************************************************************
    logic [1:0]  rst_sync_reg;
    logic        rst_n;
    logic [1:0]  ext_meta_reg;
    logic [1:0]  ext_sync_reg;
    logic [1:0]  ext_prev_reg;
    logic [15:0] pc_meta_reg;
    logic [15:0] pc_sync_reg;
    logic [15:0] pc_prev_reg;
    logic [15:0] pc_ref_reg;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Pins are read from the pad, so output-driven pins trigger as well
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ext_meta_reg <= 2'h3;
            ext_sync_reg <= 2'h3;
            ext_prev_reg <= 2'h3;
            pc_meta_reg  <= 16'h0000;
            pc_sync_reg  <= 16'h0000;
            pc_prev_reg  <= 16'h0000;
        end else begin
            ext_meta_reg <= ext_irq_pins;
            ext_sync_reg <= ext_meta_reg;
            ext_prev_reg <= ext_sync_reg;
            pc_meta_reg  <= pin_change_inputs;
            pc_sync_reg  <= pc_meta_reg;
            pc_prev_reg  <= pc_sync_reg;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [3:0] sense_reg;
    logic [1:0] enable_reg;
    logic [1:0] ext_flag_reg;
    logic [1:0] pc_ctrl_reg;
    logic [1:0] pc_flag_reg;
    logic [7:0] pc_hi_mask_reg;
    logic [7:0] pc_lo_mask_reg;
    logic       gie_reg;
    logic       wr_en;
    logic       rd_en;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;

    function automatic sense_e sense_of(input logic [3:0] s, input int p);
        return sense_e'(s[p*2 +: 2]);
    endfunction

    function automatic logic hit(input sense_e m, input logic now,
                                 input logic prev);
        unique case (m)
            SENSE_LOW:     hit = 1'b0;
            SENSE_CHANGE:  hit = now ^ prev;
            SENSE_FALLING: hit = prev & ~now;
            SENSE_RISING:  hit = now & ~prev;
        endcase
    endfunction

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sense_reg      <= SENSE_RST;
            enable_reg     <= ENABLE_RST;
            pc_ctrl_reg    <= ENABLE_RST;
            pc_hi_mask_reg <= MASK_RST;
            pc_lo_mask_reg <= MASK_RST;
            gie_reg        <= GIE_RST;
        end else if (wr_en) begin
            unique case (paddr)
                ADDR_SENSE_CTRL: sense_reg      <= pwdata[SENSE_W-1:0];
                ADDR_ENABLE:     enable_reg     <= pwdata[1:0];
                ADDR_PC_CTRL:    pc_ctrl_reg    <= pwdata[1:0];
                ADDR_PC_HI_MASK: pc_hi_mask_reg <= pwdata[7:0];
                ADDR_PC_LO_MASK: pc_lo_mask_reg <= pwdata[7:0];
                ADDR_CORE_CTRL:  gie_reg        <= pwdata[BIT_GIE];
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Dedicated pin detection
    // ****************************************************************
    logic [1:0] ext_hit;
    logic [1:0] ext_clr;
    logic [1:0] ext_level;

    always_comb begin
        for (int p = 0; p < 2; p++) begin
            // Edges only from sampled history, so clock is required
            ext_hit[p] = hit(sense_of(sense_reg, p), ext_sync_reg[p],
                             ext_prev_reg[p]);
            ext_level[p] = (sense_of(sense_reg, p) == SENSE_LOW);
            ext_clr[p] = ext_irq_ack[p] ||
                         (wr_en && paddr == ADDR_EXT_FLAGS && pwdata[p]);
        end
    end

    // Set beats clear; level mode keeps the flag at zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ext_flag_reg <= FLAGS_RST;
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (ext_level[p]) begin
                    ext_flag_reg[p] <= 1'b0;
                end else if (ext_hit[p]) begin
                    ext_flag_reg[p] <= 1'b1;
                end else if (ext_clr[p]) begin
                    ext_flag_reg[p] <= 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // Pin-change groups
    // ****************************************************************
    logic [15:0] pc_toggle;
    logic [1:0]  pc_hit;
    logic [1:0]  pc_clr;

    assign pc_toggle = pc_sync_reg ^ pc_prev_reg;
    assign pc_hit[BIT_HI] =
        |(pc_toggle[15:8] & pc_hi_mask_reg);
    assign pc_hit[BIT_LO] =
        |(pc_toggle[7:0] & pc_lo_mask_reg);

    always_comb begin
        for (int g = 0; g < 2; g++) begin
            pc_clr[g] = pin_change_ack[g] ||
                        (wr_en && paddr == ADDR_PC_FLAGS && pwdata[g]);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pc_flag_reg <= FLAGS_RST;
        end else begin
            for (int g = 0; g < 2; g++) begin
                if (pc_hit[g]) begin
                    pc_flag_reg[g] <= 1'b1;
                end else if (pc_clr[g]) begin
                    pc_flag_reg[g] <= 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // Wake reference and unclocked wake term
    // ****************************************************************
    // Reference tracks pins while awake; a differing unmasked pin of an enabled group wakes unclocked
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pc_ref_reg <= 16'h0000;
        end else begin
            pc_ref_reg <= pc_sync_reg;
        end
    end

    logic wake_async;
    logic wake_meta_reg;
    logic wake_reg;

    // Raw pins used only for wake; a stopped clock cannot sample them
    assign wake_async =
        (|((pin_change_inputs ^ pc_ref_reg) &
           {pc_hi_mask_reg & {8{pc_ctrl_reg[BIT_HI]}},
            pc_lo_mask_reg & {8{pc_ctrl_reg[BIT_LO]}}})) ||
        (enable_reg[BIT_A] && ext_level[BIT_A] && !ext_irq_pins[BIT_A]) ||
        (enable_reg[BIT_B] && ext_level[BIT_B] &&
         !ext_irq_pins[BIT_B]);

    // Registered for the flop-output rule; the power manager also sees the
    // unclocked term through its own path in a real chip
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wake_meta_reg <= 1'b0;
            wake_reg      <= 1'b0;
        end else begin
            wake_meta_reg <= wake_async;
            wake_reg      <= wake_meta_reg;
        end
    end

    // ****************************************************************
    // Requests to the core
    // ****************************************************************
    logic [1:0] ext_req_next;
    logic [1:0] pc_req_next;

    always_comb begin
        for (int p = 0; p < 2; p++) begin
            // Level request uses the sampled pin: a level gone before the
            // clock runs again gives wake but no interrupt
            ext_req_next[p] = gie_reg && enable_reg[p] &&
                (ext_level[p] ? !ext_sync_reg[p]
                              : ext_flag_reg[p]);
            pc_req_next[p] = gie_reg && pc_ctrl_reg[p] &&
                             pc_flag_reg[p];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ext_irq_a_req           <= 1'b0;
            ext_irq_b_req           <= 1'b0;
            pin_change_group_lo_irq <= 1'b0;
            pin_change_group_hi_irq <= 1'b0;
            wake_req                <= 1'b0;
        end else begin
            ext_irq_a_req           <= ext_req_next[BIT_A];
            ext_irq_b_req           <= ext_req_next[BIT_B];
            pin_change_group_lo_irq <= pc_req_next[BIT_LO];
            pin_change_group_hi_irq <= pc_req_next[BIT_HI];
            wake_req                <= wake_reg;
        end
    end

    // ****************************************************************
    // APB read and answer
    // ****************************************************************
    // Read data is latched in setup, so the access phase ends at once
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                unique case (paddr)
                    ADDR_SENSE_CTRL, ADDR_ENABLE, ADDR_EXT_FLAGS,
                    ADDR_PC_CTRL, ADDR_PC_FLAGS, ADDR_PC_HI_MASK,
                    ADDR_PC_LO_MASK, ADDR_CORE_CTRL,
                    ADDR_PIN_STATUS: pslverr <= 1'b0;
                    default:         pslverr <= 1'b1;
                endcase
            end
            if (rd_en) begin
                unique case (paddr)
                    ADDR_SENSE_CTRL: prdata <= {28'h0, sense_reg};
                    ADDR_ENABLE:     prdata <= {30'h0, enable_reg};
                    ADDR_EXT_FLAGS:  prdata <= {30'h0, ext_flag_reg};
                    ADDR_PC_CTRL:    prdata <= {30'h0, pc_ctrl_reg};
                    ADDR_PC_FLAGS:   prdata <= {30'h0, pc_flag_reg};
                    ADDR_PC_HI_MASK: prdata <= {24'h0, pc_hi_mask_reg};
                    ADDR_PC_LO_MASK: prdata <= {24'h0, pc_lo_mask_reg};
                    ADDR_CORE_CTRL:  prdata <= {31'h0, gie_reg};
                    ADDR_PIN_STATUS: prdata <= {14'h0, ext_sync_reg,
                                                pc_sync_reg};
                    default:         prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule // ext_irq

// ### ext_irq_pkg.sv
package ext_irq_pkg;

    // Register word addresses (byte offsets on APB)
    localparam logic [11:0] ADDR_SENSE_CTRL = 12'h000;
    localparam logic [11:0] ADDR_ENABLE     = 12'h004;
    localparam logic [11:0] ADDR_EXT_FLAGS  = 12'h008;
    localparam logic [11:0] ADDR_PC_CTRL    = 12'h00C;
    localparam logic [11:0] ADDR_PC_FLAGS   = 12'h010;
    localparam logic [11:0] ADDR_PC_HI_MASK = 12'h014;
    localparam logic [11:0] ADDR_PC_LO_MASK = 12'h018;
    localparam logic [11:0] ADDR_CORE_CTRL  = 12'h01C;
    localparam logic [11:0] ADDR_PIN_STATUS = 12'h020;

    // Field positions
    localparam int SENSE_A_LSB = 0;
    localparam int SENSE_B_LSB = 2;
    localparam int SENSE_W     = 4;
    localparam int BIT_A       = 0;
    localparam int BIT_B       = 1;
    localparam int BIT_LO      = 0;
    localparam int BIT_HI      = 1;
    localparam int BIT_GIE     = 0;

    // Reset values
    localparam logic [3:0] SENSE_RST  = 4'h0;
    localparam logic [1:0] ENABLE_RST = 2'h0;
    localparam logic [1:0] FLAGS_RST  = 2'h0;
    localparam logic [7:0] MASK_RST   = 8'h00;
    localparam logic       GIE_RST    = 1'b0;

    typedef enum logic [1:0] {
        SENSE_LOW     = 2'b00,
        SENSE_CHANGE  = 2'b01,
        SENSE_FALLING = 2'b10,
        SENSE_RISING  = 2'b11
    } sense_e;

endpackage

// ### ext_irq_chk.sv
`timescale 1ns/1ps
// ****************
// Request and ready checks
// ****************
module ext_irq_chk
    import ext_irq_pkg::*;
(
    // Clock, reset and bus
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    // Pins and requests
    input wire logic [1:0]  ext_irq_pins,
    input wire logic [15:0] pin_change_inputs,
    input wire logic        ext_irq_a_req,
    input wire logic        ext_irq_b_req,
    input wire logic        pin_change_group_lo_irq,
    input wire logic        pin_change_group_hi_irq
);
    logic [1:0] sns_a, en, pcen;
    logic [7:0] lo_m;
    logic       gie, ga, gb, glo, ghi;
    // Bus-side copy of the control bits, taken at the access edge
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            {sns_a, en, pcen, gie, lo_m} <= '0;
        end else if (psel && penable && pwrite && pready) begin
            case (paddr)
                ADDR_SENSE_CTRL: sns_a <= pwdata[1:0];
                ADDR_ENABLE:     en <= pwdata[1:0];
                ADDR_PC_CTRL:    pcen <= pwdata[1:0];
                ADDR_CORE_CTRL:  gie <= pwdata[0];
                ADDR_PC_LO_MASK: lo_m <= pwdata[7:0];
                default: ;
            endcase
        end
    end
    assign ga = gie && en[0];
    assign gb = gie && en[1];
    assign glo = gie && pcen[0];
    assign ghi = gie && pcen[1];
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence s_fall;
        ga && sns_a == 2'b10 && $fell(ext_irq_pins[0]);
    endsequence
    sequence s_low_held;
        (ga && sns_a == 2'b00 && !ext_irq_pins[0])[*6];
    endsequence
    property p_ready;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    property p_gate_a;
        ext_irq_a_req |-> $past(ga);
    endproperty
    property p_gate_b;
        ext_irq_b_req |-> $past(gb);
    endproperty
    property p_gate_lo;
        pin_change_group_lo_irq |-> $past(glo);
    endproperty
    property p_gate_hi;
        pin_change_group_hi_irq |-> $past(ghi);
    endproperty
    property p_fall;
        s_fall |-> ##[1:6] ext_irq_a_req;
    endproperty
    property p_level;
        s_low_held |-> ext_irq_a_req;
    endproperty
    // A change on an enabled pin of the lower group must raise it
    property p_pc_lo;
        glo && |(($past(pin_change_inputs) ^ pin_change_inputs) &
                 {8'h00, lo_m})
            |-> ##[1:6] pin_change_group_lo_irq;
    endproperty
    a_ready: assert property (p_ready)
        else $error("ready not one cycle after setup");
    a_gate_a: assert property (p_gate_a)
        else $error("pin a request while gated");
    a_gate_b: assert property (p_gate_b)
        else $error("pin b request while gated");
    a_gate_lo: assert property (p_gate_lo)
        else $error("lower group request while gated");
    a_gate_hi: assert property (p_gate_hi)
        else $error("upper group request while gated");
    a_fall: assert property (p_fall)
        else $error("falling edge missed");
    a_level: assert property (p_level)
        else $error("held low level not requesting");
    a_pc_lo: assert property (p_pc_lo)
        else $error("lower group change missed");
endmodule // ext_irq_chk

bind ext_irq ext_irq_chk chk_u (.mclk, .rst_b, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .ext_irq_pins, .pin_change_inputs,
    .ext_irq_a_req, .ext_irq_b_req, .pin_change_group_lo_irq,
    .pin_change_group_hi_irq);

// ### pin_core_model.sv
`timescale 1ns/1ps
// ****************
// Pin and core side
// ****************
module pin_core_model (
    // Bench control
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic [1:0]  pin_set,
    input wire logic [15:0] pc_set,
    input wire logic        ack_en,
    // Requests seen
    input wire logic [1:0]  req,
    input wire logic [1:0]  grp_req,
    // Toward the block
    output logic [1:0]      ext_irq_pins,
    output logic [15:0]     pin_change_inputs,
    output logic [1:0]      ext_irq_ack,
    output logic [1:0]      pin_change_ack
);
    // Idle dedicated pins sit high so level sensing stays quiet; change inputs idle low
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ext_irq_pins <= 2'h3;
            pin_change_inputs <= 16'h0000;
        end else begin
            // Levels held as long as asked, so start-up is always covered
            ext_irq_pins <= pin_set;
            pin_change_inputs <= pc_set;
        end
    end
    // Handler entry: with ack_en set, an ack every other cycle while a request is high, never two in a row
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ext_irq_ack <= 2'h0;
            pin_change_ack <= 2'h0;
        end else begin
            ext_irq_ack <= ack_en ? req & ~ext_irq_ack : 2'h0;
            pin_change_ack <= ack_en ? grp_req & ~pin_change_ack : 2'h0;
        end
    end
endmodule // pin_core_model

// ### tb.sv
`timescale 1ns/1ps
// ****************
// Bench
// ****************
module tb import ext_irq_pkg::*;;
    logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, er;
    logic a_req, b_req, lo_irq, hi_irq, ack_en, wake;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  pins, pin_set, ext_ack, pc_ack, req2;
    logic [15:0] pci, pc_set;
    int n_fail = 0, compares = 0, cycles = 0;
    logic [11:0] ra [7] = '{ADDR_SENSE_CTRL, ADDR_ENABLE, ADDR_PC_CTRL,
        ADDR_PC_HI_MASK, ADDR_PC_LO_MASK, ADDR_CORE_CTRL, 12'h030};
    logic [31:0] rw [7] = '{32'hFF, 32'hFF, 32'hFF, 32'h1A5, 32'h15A,
        32'hFF, 32'hFF};
    logic [31:0] re [7] = '{32'hF, 32'h3, 32'h3, 32'hA5, 32'h5A, 32'h1, 32'h0};
    // Per sense code: request after fall, flag after fall, request after rise
    localparam logic [3:0] EF = 4'b0111, EFL = 4'b0110, ER = 4'b1010;
    assign req2 = {b_req, a_req};
    ext_irq dut_u (.mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .ext_irq_pins(pins),
        .pin_change_inputs(pci), .ext_irq_ack(ext_ack),
        .pin_change_ack(pc_ack), .ext_irq_a_req(a_req), .ext_irq_b_req(b_req),
        .pin_change_group_lo_irq(lo_irq), .pin_change_group_hi_irq(hi_irq),
        .wake_req(wake));
    pin_core_model model_u (.mclk, .rst_b, .pin_set, .pc_set, .ack_en,
        .req(req2), .grp_req({hi_irq, lo_irq}), .ext_irq_pins(pins),
        .pin_change_inputs(pci), .ext_irq_ack(ext_ack),
        .pin_change_ack(pc_ack));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    // Waits for pready at rising edges; only the bench timeout ends a hang
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Past the four-edge request latency, checked between edges
    task automatic w8;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            print_verdict();
        end
    end
    initial begin
        {rst_b, psel, penable, pwrite, ack_en} = '0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pin_set = 2'h3;
        pc_set = 16'h0000;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (5) @(posedge mclk);
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, ra[i], 32'h0);
            check("reset value", rd, 32'h0);
            apb(1'b1, ra[i], rw[i]);
            apb(1'b0, ra[i], 32'h0);
            check("readback", rd, re[i]);
            check("slverr", 32'(er), 32'(i == 6));
        end
        for (int p = 0; p < 2; p++) begin
            for (int m = 0; m < 4; m++) begin
                apb(1'b1, ADDR_SENSE_CTRL, 32'(m) << (2 * p));
                apb(1'b1, ADDR_EXT_FLAGS, 32'h3);
                pin_set[p] <= 1'b0;
                w8();
                check("req fall", 32'(req2[p]), 32'(EF[m]));
                check("wake", 32'(wake), 32'(m == 0));
                apb(1'b0, ADDR_EXT_FLAGS, 32'h0);
                check("pin flag", 32'(rd[p]), 32'(EFL[m]));
                apb(1'b1, ADDR_EXT_FLAGS, 32'h3);
                pin_set[p] <= 1'b1;
                w8();
                check("req rise", 32'(req2[p]), 32'(ER[m]));
                check("wake idle", 32'(wake), 32'h0);
            end
        end
        apb(1'b1, ADDR_SENSE_CTRL, 32'h2);
        apb(1'b1, ADDR_EXT_FLAGS, 32'h3);
        pin_set[0] <= 1'b0;
        repeat (2) @(posedge mclk);
        pin_set[0] <= 1'b1;
        w8();
        check("short pulse", 32'(a_req), 32'h1);
        apb(1'b1, ADDR_CORE_CTRL, 32'h0);
        w8();
        check("global off", 32'(a_req), 32'h0);
        apb(1'b1, ADDR_CORE_CTRL, 32'h1);
        @(posedge mclk);
        ack_en <= 1'b1;
        w8();
        check("after ack", 32'(a_req), 32'h0);
        apb(1'b1, ADDR_PC_LO_MASK, 32'h01);
        apb(1'b1, ADDR_PC_HI_MASK, 32'h80);
        ack_en <= 1'b0;
        pc_set <= 16'h0002;
        w8();
        check("masked pin", 32'(lo_irq), 32'h0);
        @(posedge mclk);
        pc_set <= 16'h0003;
        w8();
        check("lower group", 32'(lo_irq), 32'h1);
        apb(1'b0, ADDR_PC_FLAGS, 32'h0);
        check("group flags", rd, 32'h1);
        apb(1'b1, ADDR_PC_FLAGS, 32'h1);
        w8();
        check("group cleared", 32'(lo_irq), 32'h0);
        @(posedge mclk);
        pc_set <= 16'h8003;
        w8();
        check("upper group", 32'(hi_irq), 32'h1);
        apb(1'b1, ADDR_PC_CTRL, 32'h1);
        w8();
        check("upper disabled", 32'(hi_irq), 32'h0);
        print_verdict();
    end
endmodule // tb
